// ===== logic/pms_defs.svh
// Constants of the programmable Mealy sequencer: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

`define PMS_NUM_TERMS 48
`define PMS_NUM_INPUTS 16
`define PMS_STATE_W 6
`define PMS_OUT_W 8
`define PMS_NUM_VARS 22
`define PMS_NUM_FLOPS 14

`define PMS_ADDR_CTRL 12'h000
`define PMS_ADDR_STATUS 12'h004
`define PMS_ADDR_TERMS_LO 12'h008
`define PMS_ADDR_TERMS_HI 12'h00c
`define PMS_ADDR_CMDS 12'h010

`define PMS_CTRL_RUN_BIT 0
`define PMS_CTRL_STEP_BIT 1
`define PMS_CTRL_RESET 1'b1

`define PMS_STAT_STATE_LSB 0
`define PMS_STAT_OUT_LSB 8
`define PMS_STAT_PRESET_BIT 16
`define PMS_STAT_WAIT_BIT 17
`define PMS_STAT_CVAR_BIT 18
`define PMS_CMDS_RESET_LSB 16

`define PMS_STATE_RESET 6'h3f
`define PMS_OUT_RESET 8'hff
`define PMS_DIAG_UPPER 2'h3

`endif

// ===== logic/pms_pkg.sv
// Types shared by the sequencer files.
// Assumes the constants header sits beside it.
`include "pms_defs.svh"

package pms_pkg;

   // Sequencing phase, one-hot
   typedef enum logic [2:0] {
      PMS_PH_PRESET = 3'b001,
      PMS_PH_WAIT = 3'b010,
      PMS_PH_RUN = 3'b100
   } pms_phase_e;

   typedef logic [`PMS_NUM_VARS-1:0] pms_vars_t;

endpackage : pms_pkg

// ===== logic/pms_term.sv
// One transition term of the AND array, with its complement qualifier.
// Assumes static link masks; the complement value arrives from the parent.
`timescale 1ns/1ps

module pms_term #(
   parameter int NV = 22
) (
   // Variables and links
   input wire logic [NV-1:0] vars,
   input wire logic [NV-1:0] true_sel,
   input wire logic [NV-1:0] inv_sel,
   input wire logic c_true_sel,
   input wire logic c_inv_sel,
   input wire logic c_var,
   // Results
   output logic base_term,
   output logic term
);

   // Both links intact on one variable gives zero by construction
   assign base_term = &((~true_sel | vars) & (~inv_sel | ~vars));

   // Second pass through the array once the complement has settled
   assign term = base_term & (~c_true_sel | c_var) & (~c_inv_sel | ~c_var);

endmodule : pms_term

// ===== logic/pms_top.sv
// Programmable Mealy sequencer: AND/OR arrays, S/R registers, preset or
// output enable, diagnostic view, plus an APB window for software.
// Assumes all pins synchronous to pclk; the array links are static
// parameters fixed at build time.
`timescale 1ns/1ps
`include "pms_defs.svh"

module pms_top #(
   parameter int NT = `PMS_NUM_TERMS,
   parameter int NV = `PMS_NUM_VARS,
   parameter int NF = `PMS_NUM_FLOPS,
   // AND links per term, term n at [n*NV +: NV]; all intact when unprogrammed
   parameter logic [NT*NV-1:0] AND_TRUE = '1,
   parameter logic [NT*NV-1:0] AND_INV = '1,
   // Complement variable links per term
   parameter logic [NT-1:0] C_TRUE = '1,
   parameter logic [NT-1:0] C_INV = '1,
   // Terms feeding the complement array
   parameter logic [NT-1:0] C_FEED = '1,
   // OR links, flop k at [k*NT +: NT]; k 0..5 state, 6..13 output
   parameter logic [NF*NT-1:0] OR_SET = '1,
   parameter logic [NF*NT-1:0] OR_RESET = '1
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sequencer pins
   input wire logic seq_clk,
   input wire logic diag_mux_input_zero,
   input wire logic [14:0] logic_inputs_upper,
   input wire logic dual_control_pin,
   // Option selects
   input wire logic preset_mode_sel,
   input wire logic diag_mode_sel,
   // Three-state outputs
   output logic [7:0] pin_outputs,
   output logic [7:0] pin_outputs_oe
);

   localparam int SW = `PMS_STATE_W;
   localparam int OW = `PMS_OUT_W;

   // Registers of the machine
   logic [SW-1:0] state_bits_reg;
   logic [OW-1:0] out_bits_reg;
   logic [SW-1:0] state_bits_next;
   logic [OW-1:0] out_bits_next;

   // Sequencing control
   pms_pkg::pms_phase_e phase_reg;
   pms_pkg::pms_phase_e phase_next;
   logic seq_clk_prev_reg;
   logic seq_rise;
   logic seq_fall;
   logic async_set_ones;
   logic update_en;

   // Software control
   logic run_en_reg;
   logic step_reg;

   // Array signals
   pms_pkg::pms_vars_t vars;
   logic [NT-1:0] base_terms;
   logic [NT-1:0] terms;
   logic c_var;
   logic [NF-1:0] set_cmd;
   logic [NF-1:0] reset_cmd;
   logic [NF-1:0] flops_now;
   logic [NF-1:0] flops_next;

   // APB decode
   logic apb_setup;
   logic apb_access;
   logic apb_wr;
   logic addr_hit;
   logic [31:0] rd_mux;

   // Array variables: state bits fed back above the sixteen inputs
   assign vars = {state_bits_reg, logic_inputs_upper, diag_mux_input_zero};

   // Term evaluation, one instance per transition term
   genvar gt;
   generate
      for (gt = 0; gt < NT; gt++) begin : g_term
         pms_term #(
            .NV(NV)
         ) u_term (
            .vars(vars),
            .true_sel(AND_TRUE[gt*NV +: NV]),
            .inv_sel(AND_INV[gt*NV +: NV]),
            .c_true_sel(C_TRUE[gt]),
            .c_inv_sel(C_INV[gt]),
            .c_var(c_var),
            .base_term(base_terms[gt]),
            .term(terms[gt])
         );
      end
   endgenerate

   // Complement is a NOR of the feeding terms, first pass only.
   // Feeding terms must not use the complement, otherwise it would
   // oscillate; taking the first-pass value keeps this loop-free.
   assign c_var = ~|(base_terms & C_FEED);

   // OR array, one set and one reset line per flop
   genvar gf;
   generate
      for (gf = 0; gf < NF; gf++) begin : g_or
         assign set_cmd[gf] = |(terms & OR_SET[gf*NT +: NT]);
         assign reset_cmd[gf] = |(terms & OR_RESET[gf*NT +: NT]);
         // Set and reset together is illegal; hold keeps it benign
         always_comb begin
            if (set_cmd[gf] && !reset_cmd[gf]) begin
               flops_next[gf] = 1'b1;
            end else if (reset_cmd[gf] && !set_cmd[gf]) begin
               flops_next[gf] = 1'b0;
            end else begin
               flops_next[gf] = flops_now[gf];
            end
         end
      end
   endgenerate

   assign flops_now = {out_bits_reg, state_bits_reg};
   assign state_bits_next = flops_next[SW-1:0];
   assign out_bits_next = flops_next[NF-1:SW];

   // Edges of the sequencer clock, pins already synchronous
   assign seq_rise = seq_clk & ~seq_clk_prev_reg;
   assign seq_fall = ~seq_clk & seq_clk_prev_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_clk_prev_reg <= 1'b0;
      end else begin
         seq_clk_prev_reg <= seq_clk;
      end
   end

   // Preset only exists when the pin is programmed as preset
   assign async_set_ones = preset_mode_sel & dual_control_pin;

   // Phase sequencing around preset
   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         pms_pkg::PMS_PH_PRESET: begin
            if (!async_set_ones) begin
               phase_next = pms_pkg::PMS_PH_WAIT;
            end
         end
         pms_pkg::PMS_PH_WAIT: begin
            if (async_set_ones) begin
               phase_next = pms_pkg::PMS_PH_PRESET;
            end else if (seq_fall) begin
               phase_next = pms_pkg::PMS_PH_RUN;
            end
         end
         pms_pkg::PMS_PH_RUN: begin
            if (async_set_ones) begin
               phase_next = pms_pkg::PMS_PH_PRESET;
            end
         end
         default: begin
            phase_next = pms_pkg::PMS_PH_WAIT;
         end
      endcase
   end

   // Power-on also needs a falling edge before the first real pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= pms_pkg::PMS_PH_WAIT;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // Update on a rising edge with run enabled, or on a step, in run phase only; never during preset
   assign update_en = (phase_reg == pms_pkg::PMS_PH_RUN) & ~async_set_ones &
                      ((seq_rise & run_en_reg) | step_reg);

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_bits_reg <= `PMS_STATE_RESET;
      end else if (async_set_ones) begin
         state_bits_reg <= `PMS_STATE_RESET;
      end else if (update_en) begin
         state_bits_reg <= state_bits_next;
      end
   end

   // Output register; the diagnostic view never writes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_bits_reg <= `PMS_OUT_RESET;
      end else if (async_set_ones) begin
         out_bits_reg <= `PMS_OUT_RESET;
      end else if (update_en) begin
         out_bits_reg <= out_bits_next;
      end
   end

   // Pin drive. Preset forces ones straight from the pin so the outputs
   // react in the same cycle, ahead of the registers.
   always_comb begin
      if (async_set_ones) begin
         pin_outputs = `PMS_OUT_RESET;
      end else if (diag_mode_sel) begin
         pin_outputs = {`PMS_DIAG_UPPER, state_bits_reg};
      end else begin
         pin_outputs = out_bits_reg;
      end
   end

   // In enable mode the pin is active low; preset mode always drives
   assign pin_outputs_oe = (preset_mode_sel || !dual_control_pin) ? 8'hff : 8'h00;

   // APB: zero wait states, read data captured in the setup cycle
   assign apb_setup = psel & ~penable;
   assign apb_access = psel & penable;
   assign apb_wr = apb_access & pwrite & addr_hit;
   assign pready = 1'b1;
   assign pslverr = apb_access & ~addr_hit;

   always_comb begin
      if (paddr == `PMS_ADDR_CTRL) begin
         addr_hit = 1'b1;
      end else if (paddr == `PMS_ADDR_STATUS) begin
         addr_hit = 1'b1;
      end else if (paddr == `PMS_ADDR_TERMS_LO) begin
         addr_hit = 1'b1;
      end else if (paddr == `PMS_ADDR_TERMS_HI) begin
         addr_hit = 1'b1;
      end else if (paddr == `PMS_ADDR_CMDS) begin
         addr_hit = 1'b1;
      end else begin
         addr_hit = 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (paddr == `PMS_ADDR_CTRL) begin
         rd_mux[`PMS_CTRL_RUN_BIT] = run_en_reg;
      end else if (paddr == `PMS_ADDR_STATUS) begin
         rd_mux[`PMS_STAT_STATE_LSB +: SW] = state_bits_reg;
         rd_mux[`PMS_STAT_OUT_LSB +: OW] = out_bits_reg;
         rd_mux[`PMS_STAT_PRESET_BIT] = async_set_ones;
         rd_mux[`PMS_STAT_WAIT_BIT] = (phase_reg != pms_pkg::PMS_PH_RUN);
         rd_mux[`PMS_STAT_CVAR_BIT] = c_var;
      end else if (paddr == `PMS_ADDR_TERMS_LO) begin
         rd_mux = terms[31:0];
      end else if (paddr == `PMS_ADDR_TERMS_HI) begin
         rd_mux[NT-33:0] = terms[NT-1:32];
      end else if (paddr == `PMS_ADDR_CMDS) begin
         rd_mux[NF-1:0] = set_cmd;
         rd_mux[`PMS_CMDS_RESET_LSB +: NF] = reset_cmd;
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_setup && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Run enable gates pin clocking; lets software freeze the machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_en_reg <= `PMS_CTRL_RESET;
      end else if (apb_wr && paddr == `PMS_ADDR_CTRL) begin
         run_en_reg <= pwdata[`PMS_CTRL_RUN_BIT];
      end
   end

   // Step gives one update without a pin edge; self-clearing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_reg <= 1'b0;
      end else if (apb_wr && paddr == `PMS_ADDR_CTRL) begin
         step_reg <= pwdata[`PMS_CTRL_STEP_BIT];
      end else begin
         step_reg <= 1'b0;
      end
   end

endmodule : pms_top

// ===== sim/pms_board.sv
// Board model: makes sequencer clock pulses and resolves the three-state pins.
// Assumes pclk is the bench clock and req is a one-cycle request.
`timescale 1ns/1ps

module pms_board (
   // Clock and control
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   output logic seq_clk,
   output logic busy,
   // Pins
   input wire logic [7:0] pin_outputs,
   input wire logic [7:0] pin_outputs_oe,
   output logic [7:0] board_pins
);
   logic [2:0] cnt_reg;
   logic [7:0] last_reg;

   // Three cycles high, three low; rests low between pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 3'h0;
      end else if (cnt_reg != 3'h0 || req) begin
         cnt_reg <= (cnt_reg == 3'h6) ? 3'h0 : cnt_reg + 3'h1;
      end
   end

   // Remembers the last level each line was driven to
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_reg <= 8'h00;
      end else begin
         last_reg <= (pin_outputs & pin_outputs_oe) | (last_reg & ~pin_outputs_oe);
      end
   end

   assign seq_clk = (cnt_reg != 3'h0) && (cnt_reg < 3'h4);
   assign busy = (cnt_reg != 3'h0);
   // Floated lines show the inverse of their last driven level, so a stale value never passes
   assign board_pins = (pin_outputs & pin_outputs_oe) | (~last_reg & ~pin_outputs_oe);
endmodule : pms_board

// ===== sim/pms_assertions.sv
// Checker of the sequencer pins at the top module ports.
// Assumes all pins are sampled on pclk, as in the design.
`timescale 1ns/1ps

module pms_checker (
   // Bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic pwrite,
   // Pins
   input wire logic seq_clk,
   input wire logic dual_control_pin,
   input wire logic preset_mode_sel,
   input wire logic diag_mode_sel,
   input wire logic [7:0] pin_outputs,
   input wire logic [7:0] pin_outputs_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire pre = preset_mode_sel && dual_control_pin;
   wire wr = psel && pwrite;

   chk_preset_ones: assert property (pre && !diag_mode_sel |-> pin_outputs == 8'hff)
      else $error("outputs not high in preset");
   chk_preset_drive: assert property (preset_mode_sel |-> pin_outputs_oe == 8'hff)
      else $error("outputs floated in preset mode");
   chk_oe_float: assert property (!preset_mode_sel && dual_control_pin |-> !pin_outputs_oe)
      else $error("outputs driven while disabled");
   chk_oe_drive: assert property (!preset_mode_sel && !dual_control_pin |-> &pin_outputs_oe)
      else $error("outputs floated while enabled");
   chk_diag_high: assert property (diag_mode_sel |-> pin_outputs[7:6] == 2'h3)
      else $error("upper outputs low in diagnostic view");
   chk_reset_ones: assert property ($rose(presetn) |-> pin_outputs == 8'hff)
      else $error("outputs not high after reset");
   chk_hold_no_edge: assert property (
      !(seq_clk && !$past(seq_clk)) && !wr && !$past(wr) && !$past(wr, 2)
      |=> $stable(pin_outputs) || $changed({diag_mode_sel, dual_control_pin, preset_mode_sel}))
      else $error("outputs moved without a clock rise");
   chk_wait_fall: assert property ($fell(dual_control_pin) && preset_mode_sel && !seq_clk
      && !$past(seq_clk) && !diag_mode_sel ##[1:2] $rose(seq_clk) |=> pin_outputs == 8'hff)
      else $error("rise before a fall updated the registers");

   cover property (pre);
   cover property (!preset_mode_sel && dual_control_pin);
   cover property (diag_mode_sel);
   cover property ($rose(seq_clk));
endmodule : pms_checker

bind pms_top pms_checker i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .pwrite(pwrite), .seq_clk(seq_clk),
   .dual_control_pin(dual_control_pin), .preset_mode_sel(preset_mode_sel),
   .diag_mode_sel(diag_mode_sel), .pin_outputs(pin_outputs), .pin_outputs_oe(pin_outputs_oe)
);

// ===== sim/tb_programmable_mealy_sequencer.sv
// Bench of the sequencer: APB calls, clock pulses and pin checks.
// Assumes the board model makes seq_clk and resolves the pins.
`timescale 1ns/1ps
`include "pms_defs.svh"

module tb_programmable_mealy_sequencer;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seq_clk, req, busy, e;
   logic diag_mux_input_zero, dual_control_pin, preset_mode_sel, diag_mode_sel;
   logic [11:0] paddr;
   logic [14:0] logic_inputs_upper;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] pin_outputs, pin_outputs_oe, board_pins;
   int num_errors, checked;
   // Term 0 is I-zero true, term 1 inverted; the rest stay dead
   localparam logic [1055:0] AT = {{46{22'h3fffff}}, 22'h0, 22'h1};
   localparam logic [1055:0] AI = {{46{22'h3fffff}}, 22'h1, 22'h0};
   // Set and reset of one flop never share a term
   localparam logic [671:0] OS = (672'h1 << 288) | (672'h1 << 1);
   localparam logic [671:0] OC = (672'h1 << 289) | 672'h1;

   pms_top #(.AND_TRUE(AT), .AND_INV(AI), .C_TRUE(48'h0), .C_INV(48'h0), .C_FEED(48'h0),
      .OR_SET(OS), .OR_RESET(OC)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .seq_clk(seq_clk), .diag_mux_input_zero(diag_mux_input_zero),
      .logic_inputs_upper(logic_inputs_upper), .dual_control_pin(dual_control_pin),
      .preset_mode_sel(preset_mode_sel), .diag_mode_sel(diag_mode_sel),
      .pin_outputs(pin_outputs), .pin_outputs_oe(pin_outputs_oe));
   pms_board i_board (.pclk(pclk), .presetn(presetn), .req(req), .seq_clk(seq_clk),
      .busy(busy), .pin_outputs(pin_outputs), .pin_outputs_oe(pin_outputs_oe),
      .board_pins(board_pins));

   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      checked++;
      if (g !== x) begin
         $display("mismatch %s expected %h seen %h", n, x, g);
         num_errors++;
      end
   endtask : chk

   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic pulse();
      req <= 1'b1;
      @(posedge pclk);
      req <= 1'b0;
      @(posedge pclk);
      while (busy === 1'b1) @(posedge pclk);
   endtask : pulse

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      close_out();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, req, diag_mode_sel} = '0;
      {diag_mux_input_zero, dual_control_pin, preset_mode_sel} = 3'h1;
      logic_inputs_upper = 15'h2a5a;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("pins", 8'hff, pin_outputs);
      apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
      chk("state", 32'h3f, q[5:0]);
      chk("outreg", 32'hff, q[15:8]);
      $display("test reset done");
      pulse();
      chk("wait", 8'hff, pin_outputs);
      pulse();
      chk("clear", 8'hfe, pin_outputs);
      diag_mux_input_zero <= 1'b1;
      pulse();
      chk("set", 8'hff, pin_outputs);
      diag_mode_sel <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("diag", 8'hfe, pin_outputs);
      diag_mode_sel <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("undiag", 8'hff, pin_outputs);
      $display("test sequence done");
      apb(1'b1, `PMS_ADDR_CTRL, 32'h0);
      diag_mux_input_zero <= 1'b0;
      pulse();
      chk("gated", 8'hff, pin_outputs);
      apb(1'b1, `PMS_ADDR_CTRL, 32'h3);
      repeat (2) @(posedge pclk);
      chk("step", 8'hfe, pin_outputs);
      apb(1'b0, `PMS_ADDR_TERMS_LO, 32'h0);
      chk("terms_lo", 32'h2, q);
      apb(1'b0, `PMS_ADDR_TERMS_HI, 32'h0);
      chk("terms_hi", 32'h0, q);
      apb(1'b0, `PMS_ADDR_CMDS, 32'h0);
      chk("cmds", 32'h0040_0001, q);
      apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
      chk("status", 32'h0004_fe3f, q);
      apb(1'b0, 12'h020, 32'h0);
      chk("slverr", 32'h1, e);
      chk("rdata", 32'h0, q);
      $display("test bus done");
      {preset_mode_sel, dual_control_pin, diag_mux_input_zero} <= 3'h3;
      pulse();
      chk("float", 8'h00, pin_outputs_oe);
      dual_control_pin <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("drive", 8'hff, board_pins);
      $display("test enable done");
      {preset_mode_sel, dual_control_pin, diag_mux_input_zero} <= 3'h6;
      pulse();
      chk("preset", 8'hff, pin_outputs);
      apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
      chk("pstatus", 32'h0007_ff3f, q);
      dual_control_pin <= 1'b0;
      @(posedge pclk);
      pulse();
      chk("hold", 8'hff, pin_outputs);
      apb(1'b0, `PMS_ADDR_STATUS, 32'h0);
      chk("pstate", 32'h3f, q[5:0]);
      pulse();
      chk("resume", 8'hfe, pin_outputs);
      $display("test preset done");
      close_out();
   end
endmodule : tb_programmable_mealy_sequencer
